// file: pkg/tfc_pkg.sv
// shared constants for the timer output flip-flop control block
package tfc_pkg;

    // ==========================================================
    // bus geometry
    localparam int unsigned ADDR_W = 8; // byte address width
    localparam int unsigned DATA_W = 32; // axi4-lite data width

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_RUN = 8'h00; // run control
    localparam logic [7:0] OFS_MODE = 8'h04; // timer_mode
    localparam logic [7:0] OFS_FFCR = 8'h08; // output_flipflop_control
    localparam logic [7:0] OFS_STATUS = 8'h0c; // match/overflow flags
    localparam logic [7:0] OFS_CMP0 = 8'h10; // compare_reg0
    localparam logic [7:0] OFS_CMP1 = 8'h14; // compare_reg1
    localparam logic [7:0] OFS_CAP0 = 8'h18; // capture_reg0
    localparam logic [7:0] OFS_CAP1 = 8'h1c; // capture_reg1
    localparam logic [7:0] OFS_COUNT = 8'h20; // live up-counter

    // ==========================================================
    // field positions
    localparam int unsigned RUN_BIT = 0; // counting enable
    localparam int unsigned MODE_CLK_LSB = 0; // count_clock_select
    localparam int unsigned MODE_CLE_BIT = 3; // match1_clear_enable
    localparam int unsigned MODE_SWCAP_BIT = 6; // software_capture
    localparam int unsigned FFCR_CMD_LSB = 0; // flipflop_sw_command
    localparam int unsigned FFCR_M0_BIT = 2; // toggle_on_match0
    localparam int unsigned FFCR_M1_BIT = 3; // toggle_on_match1
    localparam int unsigned FFCR_C0_BIT = 4; // toggle_on_capture0
    localparam int unsigned FFCR_C1_BIT = 5; // toggle_on_capture1
    localparam int unsigned ST_M0_BIT = 0; // match0_flag
    localparam int unsigned ST_M1_BIT = 1; // match1_flag
    localparam int unsigned ST_OVF_BIT = 2; // overflow_flag

    // ==========================================================
    // fixed read values and reset values
    localparam logic [7:0] FFCR_ONES = 8'hc3; // bits 7:6 and 1:0 read as one
    localparam logic [7:0] MODE_ONES = 8'h40; // software capture reads as one
    localparam logic [2:0] MODE_CLK_RST = 3'h0; // clock select after reset
    localparam logic MODE_CLE_RST = 1'b0; // clear enable after reset
    localparam logic [3:0] FFCR_TGL_RST = 4'h0; // toggle enables after reset
    localparam logic FF_RST = 1'b0; // output flip-flop after reset

    // ==========================================================
    // count clock select codes
    localparam logic [2:0] CLK_EXT = 3'h0; // external_count_input rising edge
    localparam logic [2:0] CLK_DIV1 = 3'h1;
    localparam logic [2:0] CLK_DIV4 = 3'h2;
    localparam logic [2:0] CLK_DIV16 = 3'h3;
    localparam logic [2:0] CLK_DIV32 = 3'h4;
    localparam logic [2:0] CLK_DIV64 = 3'h5;
    localparam logic [2:0] CLK_DIV128 = 3'h6;
    localparam logic [2:0] CLK_DIV256 = 3'h7;

    // tap masks: fires when all masked bits are one
    localparam logic [7:0] TAP_DIV1 = 8'h00;
    localparam logic [7:0] TAP_DIV4 = 8'h03;
    localparam logic [7:0] TAP_DIV16 = 8'h0f;
    localparam logic [7:0] TAP_DIV32 = 8'h1f;
    localparam logic [7:0] TAP_DIV64 = 8'h3f;
    localparam logic [7:0] TAP_DIV128 = 8'h7f;
    localparam logic [7:0] TAP_DIV256 = 8'hff;

    // ==========================================================
    // software flip-flop commands
    localparam logic [1:0] CMD_INVERT = 2'h0;
    localparam logic [1:0] CMD_SET = 2'h1;
    localparam logic [1:0] CMD_CLEAR = 2'h2;
    localparam logic [1:0] CMD_KEEP = 2'h3;

    // ==========================================================
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: pkg/tfc_edge_if.sv
// carrier for a synchronised pin level and its rising-edge pulse
`timescale 1ns/1ns
interface tfc_edge_if;
    logic level; // filtered pin level
    logic rise; // one-cycle pulse on a filtered rising edge
    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface

// file: core/tfc_sync_edge.sv
// three-flop pin synchroniser with agreement filter and edge pulse
`timescale 1ns/1ns
module tfc_sync_edge (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic pin,
    tfc_edge_if.src ev
);
    logic s1_reg; // first stage, read only by s2
    logic s2_reg;
    logic s3_reg;
    logic level_reg, level_next; // accepted level
    logic rise_reg, rise_next; // edge pulse

    // ==========================================================
    // accept a change only when stages two and three agree
    always_comb begin
        level_next = level_reg;
        rise_next = 1'b0;
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
            rise_next = s3_reg & ~level_reg;
        end
    end

    // ==========================================================
    // registers only
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
            rise_reg <= rise_next;
        end
    end

    assign ev.level = level_reg;
    assign ev.rise = rise_reg;
endmodule // tfc_sync_edge

// file: core/tfc_timer_ff.sv
// timer channel with output flip-flop control behind an axi4-lite slave
`timescale 1ns/1ns
// Overview of operation
// RULE_01 - clear enable resets counter on compare1 match
// RULE_02 - select picks external pin or prescaler tap
// RULE_03 - software rewrites mode only while stopped; writes here also land while running
// RULE_04 - bit5 toggles flip-flop on capture1 load
// RULE_05 - bit4 toggles flip-flop on capture0 load
// RULE_06 - bit3 toggles flip-flop on compare1 match
// RULE_07 - bit2 toggles flip-flop on compare0 match
// RULE_08 - command write inverts, sets, clears or keeps
// RULE_09 - command field always reads back binary 11
// RULE_10 - software capture writes load capture0, read one
// RULE_11 - flags for match0, match1 and overflow
// RULE_12 - one change per cycle, software wins
// RULE_13 - cleared counter restarts from zero next tick
module tfc_timer_ff #(
    parameter int unsigned CNT_W = 16 // up-counter width
) (
    input wire logic clock,
    input wire logic rst_n,
    // axi4-lite write address
    input wire logic [tfc_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [tfc_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [tfc_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [tfc_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // pins
    input wire logic external_count_input,
    input wire logic capture_in0,
    input wire logic capture_in1,
    output logic timer_output_flipflop
);
    localparam logic [CNT_W-1:0] CNT_MAX = '1; // counter wrap value
    localparam int unsigned PAD_W = tfc_pkg::DATA_W - CNT_W; // read padding

    // ==========================================================
    // pin synchronisers
    tfc_edge_if ext_if ();
    tfc_edge_if cap0_if ();
    tfc_edge_if cap1_if ();

    tfc_sync_edge u_sync_ext (
        .clock(clock),
        .rst_n(rst_n),
        .pin(external_count_input),
        .ev(ext_if)
    );
    tfc_sync_edge u_sync_cap0 (
        .clock(clock),
        .rst_n(rst_n),
        .pin(capture_in0),
        .ev(cap0_if)
    );
    tfc_sync_edge u_sync_cap1 (
        .clock(clock),
        .rst_n(rst_n),
        .pin(capture_in1),
        .ev(cap1_if)
    );

    // ==========================================================
    // bus state
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic aw_full_reg, aw_full_next; // address held
    logic w_full_reg, w_full_next; // data held
    logic [tfc_pkg::ADDR_W-1:0] waddr_reg, waddr_next;
    logic [tfc_pkg::DATA_W-1:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [tfc_pkg::DATA_W-1:0] rdata_reg, rdata_next;
    logic wr_fire; // register write happens this cycle
    logic rd_status; // status read clears the flags

    // ==========================================================
    // timer state
    logic run_reg, run_next;
    logic [2:0] clk_sel_reg, clk_sel_next;
    logic cle_reg, cle_next;
    logic [3:0] tgl_reg, tgl_next; // {cap1, cap0, match1, match0}
    logic ff_reg, ff_next;
    logic [2:0] status_reg, status_next;
    logic [CNT_W-1:0] count_reg, count_next;
    logic [CNT_W-1:0] cmp0_reg, cmp0_next;
    logic [CNT_W-1:0] cmp1_reg, cmp1_next;
    logic [CNT_W-1:0] cap0_reg, cap0_next;
    logic [CNT_W-1:0] cap1_reg, cap1_next;
    logic [7:0] presc_reg, presc_next; // free-running prescaler

    // byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // word decode ignores the two byte bits
    function automatic logic hit(input logic [tfc_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        return a[tfc_pkg::ADDR_W-1:2] == ofs[7:2];
    endfunction

    // the map is one dense run of words up to the live counter
    function automatic logic mapped(input logic [tfc_pkg::ADDR_W-1:0] a);
        return a[tfc_pkg::ADDR_W-1:2] <= tfc_pkg::OFS_COUNT[7:2];
    endfunction

    // ==========================================================
    // axi4-lite slave: address and data taken in either order
    always_comb begin
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        rd_status = 1'b0;
        wr_fire = 1'b0;
        // retire the response first
        if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (awvalid && awready_reg) begin
            aw_full_next = 1'b1;
            waddr_next = awaddr;
        end
        if (wvalid && wready_reg) begin
            w_full_next = 1'b1;
            wdata_next = wdata;
            wstrb_next = wstrb;
        end
        // both halves held: commit
        if (aw_full_reg && w_full_reg && !bvalid_reg) begin
            wr_fire = 1'b1;
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = mapped(waddr_reg) ? tfc_pkg::RESP_OKAY : tfc_pkg::RESP_SLVERR;
        end
        awready_next = !aw_full_next;
        wready_next = !w_full_next;
        // read path
        if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
        if (arvalid && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next = mapped(araddr) ? tfc_pkg::RESP_OKAY : tfc_pkg::RESP_SLVERR;
            rdata_next = '0;
            if (hit(araddr, tfc_pkg::OFS_RUN)) begin
                rdata_next[tfc_pkg::RUN_BIT] = run_reg;
            end else if (hit(araddr, tfc_pkg::OFS_MODE)) begin
                rdata_next[7:0] = tfc_pkg::MODE_ONES; // RULE_10
                rdata_next[tfc_pkg::MODE_CLE_BIT] = cle_reg;
                rdata_next[tfc_pkg::MODE_CLK_LSB +: 3] = clk_sel_reg;
            end else if (hit(araddr, tfc_pkg::OFS_FFCR)) begin
                rdata_next[7:0] = tfc_pkg::FFCR_ONES; // RULE_09
                rdata_next[tfc_pkg::FFCR_M0_BIT +: 4] = tgl_reg;
            end else if (hit(araddr, tfc_pkg::OFS_STATUS)) begin
                rdata_next[2:0] = status_reg;
                rd_status = 1'b1; // reading clears the flags
            end else if (hit(araddr, tfc_pkg::OFS_CMP0)) begin
                rdata_next = {{PAD_W{1'b0}}, cmp0_reg};
            end else if (hit(araddr, tfc_pkg::OFS_CMP1)) begin
                rdata_next = {{PAD_W{1'b0}}, cmp1_reg};
            end else if (hit(araddr, tfc_pkg::OFS_CAP0)) begin
                rdata_next = {{PAD_W{1'b0}}, cap0_reg};
            end else if (hit(araddr, tfc_pkg::OFS_CAP1)) begin
                rdata_next = {{PAD_W{1'b0}}, cap1_reg};
            end else if (hit(araddr, tfc_pkg::OFS_COUNT)) begin
                rdata_next = {{PAD_W{1'b0}}, count_reg};
            end
        end
    end

    // ==========================================================
    // bus registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= tfc_pkg::RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rresp_reg <= tfc_pkg::RESP_OKAY;
            rdata_reg <= '0;
        end else begin
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================================
    // timer: count tick, matches, captures, flip-flop, flags
    logic [7:0] tap; // selected prescaler mask
    logic tick; // one counting clock
    logic match0, match1, ovf; // counter events
    logic cap0_evt, cap1_evt; // capture loads
    logic lo_wr; // low byte lane written
    logic hw_toggle; // any enabled hardware trigger
    logic [31:0] merged; // partial-write helper
    always_comb begin
        run_next = run_reg;
        clk_sel_next = clk_sel_reg;
        cle_next = cle_reg;
        tgl_next = tgl_reg;
        ff_next = ff_reg;
        cmp0_next = cmp0_reg;
        cmp1_next = cmp1_reg;
        cap0_next = cap0_reg;
        cap1_next = cap1_reg;
        count_next = count_reg;
        presc_next = presc_reg + 8'h01;
        merged = '0;
        lo_wr = wr_fire && wstrb_reg[0];
        // tap selection for the counting clock
        unique case (clk_sel_reg)
            tfc_pkg::CLK_DIV1: tap = tfc_pkg::TAP_DIV1;
            tfc_pkg::CLK_DIV4: tap = tfc_pkg::TAP_DIV4;
            tfc_pkg::CLK_DIV16: tap = tfc_pkg::TAP_DIV16;
            tfc_pkg::CLK_DIV32: tap = tfc_pkg::TAP_DIV32;
            tfc_pkg::CLK_DIV64: tap = tfc_pkg::TAP_DIV64;
            tfc_pkg::CLK_DIV128: tap = tfc_pkg::TAP_DIV128;
            tfc_pkg::CLK_DIV256: tap = tfc_pkg::TAP_DIV256;
            tfc_pkg::CLK_EXT: tap = tfc_pkg::TAP_DIV1;
        endcase
        if (clk_sel_reg == tfc_pkg::CLK_EXT) begin
            tick = run_reg && ext_if.rise; // RULE_02
        end else begin
            tick = run_reg && ((presc_reg & tap) == tap); // RULE_02
        end
        // match seen on the tick that leaves the matching value
        match0 = tick && (count_reg == cmp0_reg);
        match1 = tick && (count_reg == cmp1_reg);
        ovf = tick && (count_reg == CNT_MAX) && !(cle_reg && match1);
        // stopped counter sits at zero
        if (!run_reg) begin
            count_next = '0;
        end else if (tick) begin
            if (cle_reg && match1) begin
                count_next = '0; // RULE_01 RULE_13
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
        // software capture: a zero written to its bit
        cap0_evt = cap0_if.rise
            || (lo_wr && hit(waddr_reg, tfc_pkg::OFS_MODE)
                && !wdata_reg[tfc_pkg::MODE_SWCAP_BIT]); // RULE_10
        cap1_evt = cap1_if.rise;
        if (cap0_evt) begin
            cap0_next = count_reg;
        end
        if (cap1_evt) begin
            cap1_next = count_reg;
        end
        // several triggers in one cycle collapse to one toggle
        hw_toggle = (tgl_reg[3] && cap1_evt) // RULE_04
            || (tgl_reg[2] && cap0_evt) // RULE_05
            || (tgl_reg[1] && match1) // RULE_06
            || (tgl_reg[0] && match0); // RULE_07
        if (hw_toggle) begin
            ff_next = !ff_reg; // RULE_12
        end
        // register writes
        if (lo_wr && hit(waddr_reg, tfc_pkg::OFS_RUN)) begin
            run_next = wdata_reg[tfc_pkg::RUN_BIT];
        end
        // mode not locked while running
        if (lo_wr && hit(waddr_reg, tfc_pkg::OFS_MODE)) begin
            cle_next = wdata_reg[tfc_pkg::MODE_CLE_BIT]; // RULE_01
            clk_sel_next = wdata_reg[tfc_pkg::MODE_CLK_LSB +: 3]; // RULE_02
        end
        if (lo_wr && hit(waddr_reg, tfc_pkg::OFS_FFCR)) begin
            tgl_next = wdata_reg[tfc_pkg::FFCR_M0_BIT +: 4];
            // software invert, set or clear beats hardware toggles; keep lets them through
            unique case (wdata_reg[tfc_pkg::FFCR_CMD_LSB +: 2]) // RULE_08 RULE_12
                tfc_pkg::CMD_INVERT: ff_next = !ff_reg;
                tfc_pkg::CMD_SET: ff_next = 1'b1;
                tfc_pkg::CMD_CLEAR: ff_next = 1'b0;
                tfc_pkg::CMD_KEEP: ff_next = ff_next;
            endcase
        end
        if (wr_fire && hit(waddr_reg, tfc_pkg::OFS_CMP0)) begin
            merged = merge({{PAD_W{1'b0}}, cmp0_reg}, wdata_reg, wstrb_reg);
            cmp0_next = merged[CNT_W-1:0];
        end
        if (wr_fire && hit(waddr_reg, tfc_pkg::OFS_CMP1)) begin
            merged = merge({{PAD_W{1'b0}}, cmp1_reg}, wdata_reg, wstrb_reg);
            cmp1_next = merged[CNT_W-1:0];
        end
        // flags: a new event wins over the read clear
        status_next = rd_status ? 3'h0 : status_reg;
        status_next[tfc_pkg::ST_M0_BIT] = status_next[tfc_pkg::ST_M0_BIT] | match0; // RULE_11
        status_next[tfc_pkg::ST_M1_BIT] = status_next[tfc_pkg::ST_M1_BIT] | match1; // RULE_11
        status_next[tfc_pkg::ST_OVF_BIT] = status_next[tfc_pkg::ST_OVF_BIT] | ovf; // RULE_11
    end

    // ==========================================================
    // timer registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            run_reg <= 1'b0;
            clk_sel_reg <= tfc_pkg::MODE_CLK_RST;
            cle_reg <= tfc_pkg::MODE_CLE_RST;
            tgl_reg <= tfc_pkg::FFCR_TGL_RST;
            ff_reg <= tfc_pkg::FF_RST;
            status_reg <= '0;
            count_reg <= '0;
            cmp0_reg <= '0;
            cmp1_reg <= '0;
            cap0_reg <= '0;
            cap1_reg <= '0;
            presc_reg <= '0;
        end else begin
            run_reg <= run_next;
            clk_sel_reg <= clk_sel_next;
            cle_reg <= cle_next;
            tgl_reg <= tgl_next;
            ff_reg <= ff_next;
            status_reg <= status_next;
            count_reg <= count_next;
            cmp0_reg <= cmp0_next;
            cmp1_reg <= cmp1_next;
            cap0_reg <= cap0_next;
            cap1_reg <= cap1_next;
            presc_reg <= presc_next;
        end
    end

    // ==========================================================
    // outputs straight from flops
    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;
    assign timer_output_flipflop = ff_reg;
endmodule // tfc_timer_ff

// file: sim/tfc_timer_ff_sva.sv
// port checker for the timer flip-flop control block
`timescale 1ns/1ns
module tfc_timer_ff_sva (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic timer_output_flipflop
);
    // ==========
    // one clock domain, one reset
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // both write halves taken at one edge
    sequence s_wr;
        awvalid && awready && wvalid && wready;
    endsequence
    // read address taken
    sequence s_rd;
        arvalid && arready;
    endsequence
    a_wr_answer: assert property (s_wr |=> !bvalid ##1 bvalid) else $error("write answer late");
    a_b_holds: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
    a_rd_answer: assert property (s_rd |=> rvalid) else $error("read answer late");
    a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data moved");
    a_ar_closed: assert property (rvalid |-> !arready) else $error("arready while busy");
    a_cmd_ones: assert property (s_rd ##0 araddr == tfc_pkg::OFS_FFCR |=>
        &{rdata[7:6], rdata[1:0]}) else $error("ffcr fixed bits wrong");
    a_cap_one: assert property (s_rd ##0 araddr == tfc_pkg::OFS_MODE |=> rdata[6])
        else $error("capture bit not one");
    a_unmapped: assert property (s_rd ##0 araddr > tfc_pkg::OFS_COUNT |=>
        rresp == tfc_pkg::RESP_SLVERR) else $error("unmapped read not refused");
    a_reset_quiet: assert property ($rose(rst_n) |-> !timer_output_flipflop && !bvalid && !rvalid)
        else $error("outputs busy after reset");
endmodule // tfc_timer_ff_sva
bind tfc_timer_ff tfc_timer_ff_sva u_sva (.clock, .rst_n, .awvalid, .awready, .wvalid, .wready,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .timer_output_flipflop);

// file: sim/tfc_pin_model.sv
// pin-side model driving the count and capture inputs
`timescale 1ns/1ns
module tfc_pin_model (
    input wire logic clock,
    output logic [2:0] pins
);
    // count, capture0, capture1; idle low
    initial pins = 3'h0;
    // four cycles high, four low
    task automatic pulse(input int i);
        pins[i] <= 1'b1;
        repeat (4) @(posedge clock);
        pins[i] <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
endmodule // tfc_pin_model

// file: sim/tfc_timer_ff_bench.sv
// self-checking bench for the timer flip-flop control block
`timescale 1ns/1ns
module tfc_timer_ff_bench;
    logic clock = 1'b0, rst_n = 1'b0, ffo;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, arready, bvalid, rvalid;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [1:0] bresp, rresp;
    logic [2:0] pins;
    int n_errors = 0, checked = 0;
    // bready and rready held high
    tfc_timer_ff DUT (.clock, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
        .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready(1'b1), .external_count_input(pins[0]), .capture_in0(pins[1]),
        .capture_in1(pins[2]), .timer_output_flipflop(ffo));
    tfc_pin_model pm (.clock, .pins);
    initial forever #5 clock = ~clock;
    // ==========
    // report and end
    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g, int t = 0);
        checked++;
        if (^g === 1'bx || g + t < e || g > e + t) begin
            n_errors++;
            $display("BAD %s exp %0d got %0d", w, e, g);
        end
    endtask
    // flag settled at a negedge, then the edge that samples it
    task automatic wait_hi(ref logic s);
        int i;
        @(negedge clock);
        for (i = 0; i < 300 && s !== 1'b1; i++) @(negedge clock);
        if (s !== 1'b1) begin
            n_errors++;
            stop_test();
        end
        @(posedge clock);
    endtask
    // ==========
    // bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        wait_hi(awready);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wait_hi(bvalid);
        chk("bresp", er, bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er = 2'h0);
        araddr <= a;
        arvalid <= 1'b1;
        wait_hi(arready);
        arvalid <= 1'b0;
        wait_hi(rvalid);
        rv = rdata;
        chk("rresp", er, rresp);
    endtask
    // ==========
    // scenarios
    task automatic t_reset;
        rd(tfc_pkg::OFS_FFCR);
        chk("ffcr", 32'hc3, rv);
        rd(tfc_pkg::OFS_MODE);
        chk("mode", 32'h40, rv);
        rd(8'h30, tfc_pkg::RESP_SLVERR);
        wr(8'h30, 32'h0, tfc_pkg::RESP_SLVERR);
    endtask
    // set, invert, keep, clear, invert
    task automatic t_cmd;
        logic [1:0] c [5] = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h0};
        logic e [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 5; i++) begin
            wr(tfc_pkg::OFS_FFCR, {30'h0, c[i]});
            chk("ff", e[i], ffo);
        end
        rd(tfc_pkg::OFS_FFCR);
        chk("cmd", 32'hc3, rv);
    endtask
    // trigger t against enable bit b+2
    task automatic t_trig;
        wr(tfc_pkg::OFS_CMP0, 32'h2);
        wr(tfc_pkg::OFS_CMP1, 32'h6);
        wr(tfc_pkg::OFS_MODE, 32'h2);
        for (int t = 0; t < 4; t++) for (int b = 0; b < 4; b++) begin
            wr(tfc_pkg::OFS_RUN, 32'h0);
            wr(tfc_pkg::OFS_FFCR, (32'h1 << (b + 2)) | 32'h2);
            if (t < 2) begin
                wr(tfc_pkg::OFS_RUN, 32'h1);
                repeat (t ? 60 : 16) @(posedge clock);
                wr(tfc_pkg::OFS_RUN, 32'h0);
            end else pm.pulse(t - 1);
            chk("ff", b == t || (t == 1 && b == 0), ffo);
            rd(tfc_pkg::OFS_STATUS);
            chk("status", t == 0 ? 1 : t == 1 ? 3 : 0, rv);
        end
    endtask
    task automatic t_clear;
        wr(tfc_pkg::OFS_FFCR, 32'h3);
        wr(tfc_pkg::OFS_CMP1, 32'h5);
        wr(tfc_pkg::OFS_MODE, 32'h9);
        wr(tfc_pkg::OFS_RUN, 32'h1);
        for (int i = 0; i < 8; i++) begin
            rd(tfc_pkg::OFS_COUNT);
            chk("count", 2, rv, 3);
        end
        wr(tfc_pkg::OFS_RUN, 32'h0);
        wr(tfc_pkg::OFS_MODE, 32'h1);
        wr(tfc_pkg::OFS_RUN, 32'h1);
        repeat (20) @(posedge clock);
        rd(tfc_pkg::OFS_COUNT);
        chk("count", 24, rv, 6);
    endtask
    // each source: pin pulses, then taps over 512 cycles
    task automatic t_clk;
        int dv [8] = '{0, 1, 4, 16, 32, 64, 128, 256};
        for (int k = 0; k < 8; k++) begin
            wr(tfc_pkg::OFS_RUN, 32'h0);
            wr(tfc_pkg::OFS_MODE, k);
            wr(tfc_pkg::OFS_RUN, 32'h1);
            if (k == 0) repeat (3) pm.pulse(0);
            else repeat (512) @(posedge clock);
            rd(tfc_pkg::OFS_COUNT);
            chk("count", k ? 512 / dv[k] : 3, rv, k == 1 ? 8 : k ? 2 : 0);
        end
    endtask
    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (2) @(posedge clock);
        t_reset();
        t_cmd();
        t_trig();
        t_clear();
        t_clk();
        stop_test();
    end
endmodule // tfc_timer_ff_bench
